// file: hw/data_access_break_unit.sv
// data access break unit: one masked data ram break condition
// Operation
// - break only when address, data and direction match in one access
// - data field takes any value 0 to F or is fully masked
// - direction matches reads, writes, or either when masked
// - each data bit can be masked separately, e.g. 1*1* on writes
// - masked direction, address 074 data 5 breaks on read or write
// - one condition only, independent of other break units
// - host clear marks condition absent, no breaks until set again
// - arming multiple condition break cancels the data break condition
`default_nettype none
module data_access_break_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ram_valid,
  input wire logic ram_write,
  input wire logic [11:0] ram_addr,
  input wire logic [3:0] ram_data,
  input wire logic [3:0] reg_addr,
  input wire logic [11:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [11:0] reg_rdata,
  output logic break_req
);
  // ----------------------------------------------------------------
  // condition registers
  // ----------------------------------------------------------------
  logic present;
  logic [11:0] want_addr;
  logic [7:0] want_data;
  data_break_pkg::dir_t want_dir;
  logic hit;
  logic [11:0] next_rdata;
  ram_access_if acc ();
  assign acc.valid = ram_valid;
  assign acc.write = ram_write;
  assign acc.addr = ram_addr;
  assign acc.data = ram_data;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr && reg_addr == data_break_pkg::OFS_CTRL;
  wire wr_addr = reg_wr && reg_addr == data_break_pkg::OFS_ADDR;
  wire wr_data = reg_wr && reg_addr == data_break_pkg::OFS_DATA;
  wire do_arm = wr_ctrl && reg_wdata[data_break_pkg::CTRL_ARM];
  wire clear_req = wr_ctrl && reg_wdata[data_break_pkg::CTRL_CLEAR];
  wire multi_req = wr_ctrl && reg_wdata[data_break_pkg::CTRL_MULTI];
  wire [1:0] arm_dir = reg_wdata[data_break_pkg::CTRL_DIR_LO +: 2];
  wire [7:0] data_field = reg_wdata[7:0];
  // clear and multiple-condition arming both drop the condition; clear wins over arm
  wire do_drop = clear_req || multi_req;

  // ----------------------------------------------------------------
  // condition state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      present <= 1'b0;
    end else if (do_drop) begin
      present <= 1'b0;
    end else if (do_arm) begin
      present <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      want_addr <= data_break_pkg::ADDR_RST;
    end else if (wr_addr) begin
      want_addr <= reg_wdata;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      want_data <= data_break_pkg::DATA_RST;
    end else if (wr_data) begin
      want_data <= data_field;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      want_dir <= data_break_pkg::DIR_RST;
    end else if (do_arm) begin
      want_dir <= data_break_pkg::dir_t'(arm_dir);
    end
  end

  // ----------------------------------------------------------------
  // compare, combinational so the break lands in the access cycle
  // ----------------------------------------------------------------
  break_compare u_cmp (
    .acc(acc),
    .present(present),
    .want_addr(want_addr),
    .want_data(want_data[3:0]),
    .care(want_data[7:4]),
    .want_dir(want_dir),
    .hit(hit)
  );
  assign break_req = hit;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  assign next_rdata =
    (reg_addr == data_break_pkg::OFS_ADDR) ? want_addr :
    (reg_addr == data_break_pkg::OFS_DATA) ? {4'h0, want_data} :
    (reg_addr == data_break_pkg::OFS_STAT) ? {9'h000, want_dir, present} :
    12'h000;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 12'h000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 12'h000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence drop_s;
    do_drop;
  endsequence
  sequence absent_s;
    !present;
  endsequence
  sequence arm_s;
    do_arm && !do_drop;
  endsequence
  sequence present_s;
    present;
  endsequence
  sequence stat_rd_s;
    reg_rd && reg_addr == data_break_pkg::OFS_STAT;
  endsequence
  sequence data_rd_s;
    reg_rd && reg_addr == data_break_pkg::OFS_DATA;
  endsequence

  // ----------------------------------------------------------------
  // register side checks
  // ----------------------------------------------------------------
  cleared_no_break_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    drop_s |=> absent_s ##0 !break_req)
    else $error("break after clear");
  multi_cancel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    multi_req |=> absent_s)
    else $error("multi kept data break");
  clear_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (do_arm && clear_req) |=> absent_s)
    else $error("arm beat clear");
  arm_sets_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    arm_s |=> present_s)
    else $error("arm left condition absent");
  stays_absent_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (absent_s ##0 !do_arm) |=> absent_s)
    else $error("condition back without arm");
  addr_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_addr |=> want_addr == $past(reg_wdata))
    else $error("address not held");
  data_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_data |=> want_data == $past(data_field))
    else $error("data and mask not held");
  dir_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    do_arm |=> want_dir == $past(arm_dir))
    else $error("direction not latched on arm");
  read_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == data_break_pkg::OFS_ADDR) |=> reg_rdata == $past(want_addr))
    else $error("bad read back");
  data_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_rd_s |=> reg_rdata == {4'h0, $past(want_data)})
    else $error("bad data read back");
  stat_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stat_rd_s |=> reg_rdata == {9'h000, $past(want_dir), $past(present)})
    else $error("bad status read back");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 12'h000)
    else $error("read data outside read cycle");

  // ----------------------------------------------------------------
  // break side checks
  // ----------------------------------------------------------------
  wire [3:0] bit_ok;
  // per-bit view of the mask, kept apart from the xor form so the two cross-check
  for (genvar i = 0; i < 4; i++) begin : g_bit_ok
    assign bit_ok[i] = !want_data[data_break_pkg::DATA_MASK_LO + i]
      || ram_data[i] == want_data[i];
  end
  break_match_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    break_req |-> ram_valid && ram_addr == want_addr)
    else $error("break on wrong addr");
  addr_miss_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ram_valid && ram_addr != want_addr) |-> !break_req)
    else $error("break on other address");
  masked_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    break_req |-> ((ram_data ^ want_data[3:0]) & want_data[7:4]) == 4'h0)
    else $error("break on wrong data");
  bitwise_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    break_req |-> &bit_ok)
    else $error("break with a compared bit off");
  dir_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (break_req && want_dir == data_break_pkg::DIR_WRITE) |-> ram_write)
    else $error("write break on read");
  dir_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (break_req && want_dir == data_break_pkg::DIR_READ) |-> !ram_write)
    else $error("read break on write");
  // a missed break is silent at the halt logic, so every masked match with direction DIR_ANY is held to fire
  break_fires_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (present && ram_valid && ram_addr == want_addr && &bit_ok
     && want_dir == data_break_pkg::DIR_ANY) |-> break_req)
    else $error("missed break");
  pattern_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (present && ram_valid && ram_write && ram_addr == want_addr && want_data == 8'hAA
     && want_dir == data_break_pkg::DIR_WRITE && ram_data[3] && ram_data[1]) |-> break_req)
    else $error("pattern write missed");
  absent_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    absent_s |-> !break_req)
    else $error("break while absent");
  no_idle_break_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ram_valid |-> !break_req)
    else $error("break without access");
endmodule : data_access_break_unit
`default_nettype wire

// file: hw/data_break_pkg.sv
// constants shared by the data access break unit
`default_nettype none
package data_break_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 4;
  // register offsets on the plain debug port
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ADDR = 4'h1;
  localparam logic [3:0] OFS_DATA = 4'h2;
  localparam logic [3:0] OFS_STAT = 4'h3;
  // control field positions
  localparam int CTRL_ARM = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_DIR_LO = 2;
  localparam int CTRL_MULTI = 4;
  // data register: value in [3:0], care mask in [7:4]
  localparam int DATA_MASK_LO = 4;
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  typedef enum logic [1:0] {
    DIR_ANY = 2'h0,
    DIR_READ = 2'h1,
    DIR_WRITE = 2'h2
  } dir_t;
  localparam dir_t DIR_RST = DIR_ANY;
endpackage : data_break_pkg
`default_nettype wire

// file: hw/ram_access_if.sv
// data ram access carried to the comparator
`default_nettype none
interface ram_access_if;
  logic valid;
  logic write;
  logic [11:0] addr;
  logic [3:0] data;
  modport src (output valid, output write, output addr, output data);
  modport dst (input valid, input write, input addr, input data);
endinterface : ram_access_if
`default_nettype wire

// file: hw/break_compare.sv
// masked compare of one ram access against the held condition
`default_nettype none
module break_compare (
  ram_access_if.dst acc,
  input wire logic present,
  input wire logic [11:0] want_addr,
  input wire logic [3:0] want_data,
  input wire logic [3:0] care,
  input wire data_break_pkg::dir_t want_dir,
  output logic hit
);
  wire addr_ok = acc.addr == want_addr;
  // masked bits never block a break
  wire data_ok = ((acc.data ^ want_data) & care) == 4'h0;
  wire dir_ok = (want_dir == data_break_pkg::DIR_ANY)
    || (want_dir == data_break_pkg::DIR_WRITE && acc.write)
    || (want_dir == data_break_pkg::DIR_READ && !acc.write);
  assign hit = present && acc.valid && addr_ok && data_ok && dir_ok;
endmodule : break_compare
`default_nettype wire

// file: tb/ram_bus_model.sv
// emulated cpu data ram bus: one access per call
`default_nettype none
module ram_bus_model (
  input wire logic sys_clk,
  output logic ram_valid,
  output logic ram_write,
  output logic [11:0] ram_addr,
  output logic [3:0] ram_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ram_valid = 1'b0;
    ram_write = 1'b0;
    ram_addr = 12'h000;
    ram_data = 4'h0;
  end
  // one access a cycle, held up to the next edge
  task automatic access(input logic w, input logic [11:0] a, input logic [3:0] d);
    @(posedge sys_clk);
    ram_valid <= 1'b1;
    ram_write <= w;
    ram_addr <= a;
    ram_data <= d;
    @(negedge sys_clk);
  endtask : access
  // released lines are inverted so a stale value never looks like a match
  task automatic idle();
    @(posedge sys_clk);
    ram_valid <= 1'b0;
    ram_addr <= ~ram_addr;
    ram_data <= ~ram_data;
  endtask : idle
endmodule : ram_bus_model
`default_nettype wire

// file: tb/data_access_break_unit_tb.sv
// self-checking bench for the data access break unit
`default_nettype none
module data_access_break_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, reg_wr, reg_rd, break_req, ram_valid, ram_write, c_on;
  logic [11:0] ram_addr, reg_wdata, reg_rdata, c_addr;
  logic [3:0] ram_data, reg_addr, c_val, c_care;
  logic [1:0] c_dir;
  logic [7:0] seed;
  int n_mismatch, checks_done;
  data_access_break_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .ram_valid(ram_valid),
    .ram_write(ram_write), .ram_addr(ram_addr), .ram_data(ram_data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .break_req(break_req));
  ram_bus_model bus (.sys_clk(sys_clk), .ram_valid(ram_valid), .ram_write(ram_write),
    .ram_addr(ram_addr), .ram_data(ram_data));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic exp_hit(input logic w, input logic [11:0] a, input logic [3:0] d);
    return c_on && a == c_addr && ((d ^ c_val) & c_care) == 4'h0
      && (c_dir == 2'h0 || c_dir == {w, ~w});
  endfunction : exp_hit
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [11:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask : rd_chk
  task automatic arm(input logic [11:0] a, input logic [3:0] v, c, input logic [1:0] dr);
    wr(data_break_pkg::OFS_ADDR, a);
    wr(data_break_pkg::OFS_DATA, {4'h0, c, v});
    wr(data_break_pkg::OFS_CTRL, {8'h00, dr, 2'b01});
    {c_on, c_addr, c_val, c_care, c_dir} = {1'b1, a, v, c, dr};
  endtask : arm
  task automatic hit(input logic w, input logic [11:0] a, input logic [3:0] d);
    bus.access(w, a, d);
    chk({11'h000, break_req}, {11'h000, exp_hit(w, a, d)});
    bus.idle();
  endtask : hit
  task automatic rand_run(input string name);
    repeat (40) begin
      seed = lfsr(seed);
      hit(seed[0], seed[1] ? c_addr : {4'h0, seed}, seed[7:4]);
    end
    bus.idle();
    $display("test %0s done", name);
  endtask : rand_run
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // ----------------
  // main sequence
  // ----------------
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, c_on, n_mismatch, checks_done} = '0;
    seed = 8'h30;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(data_break_pkg::OFS_STAT, 12'h000);
    rd_chk(4'hF, 12'h000);
    arm(12'h074, 4'h5, 4'hF, 2'h0);
    rd_chk(data_break_pkg::OFS_ADDR, 12'h074);
    rd_chk(data_break_pkg::OFS_DATA, 12'h0F5);
    rd_chk(data_break_pkg::OFS_STAT, 12'h001);
    hit(1'b1, 12'h074, 4'h5);
    hit(1'b0, 12'h074, 4'h5);
    hit(1'b0, 12'h074, 4'h4);
    hit(1'b1, 12'h075, 4'h5);
    $display("test directed done");
    arm(12'h074, 4'hA, 4'hA, 2'h2);
    rand_run("pattern");
    arm(12'h3C1, 4'h0, 4'h0, 2'h1);
    rand_run("masked");
    wr(data_break_pkg::OFS_CTRL, 12'h002);
    c_on = 1'b0;
    rd_chk(data_break_pkg::OFS_STAT, 12'h002);
    hit(1'b0, 12'h3C1, 4'h0);
    $display("test clear done");
    arm(12'h074, 4'h5, 4'hF, 2'h0);
    wr(data_break_pkg::OFS_CTRL, 12'h010);
    c_on = 1'b0;
    hit(1'b1, 12'h074, 4'h5);
    rd_chk(data_break_pkg::OFS_STAT, 12'h000);
    $display("test multi done");
    arm(12'h2B7, 4'h9, 4'hF, 2'h2);
    hit(1'b1, 12'h2B7, 4'h9);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    c_on = 1'b0;
    rd_chk(data_break_pkg::OFS_STAT, 12'h000);
    rd_chk(data_break_pkg::OFS_ADDR, data_break_pkg::ADDR_RST);
    hit(1'b1, 12'h2B7, 4'h9);
    $display("test reset done");
    report_and_stop();
  end
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : data_access_break_unit_tb
`default_nettype wire
